// File: core/tssd_pkg.sv
// constants, types and register map of the trigger sequencer step decoder
// assumes a 16-bit register file behind a 32-bit AXI4-Lite slave
package tssd_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PROG_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned LIM_COUNT = 6;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned TRIG_W = 16;

    // ****************************************
    // step command layout and codes
    // ****************************************
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] opt;
    } tssd_step_t;

    localparam logic [3:0] CMD_CONTROL = 4'h0;
    localparam logic [3:0] CMD_LIMIT = 4'h1;

    localparam logic [3:0] OPT_SD_OFF = 4'h2;
    localparam logic [3:0] OPT_SD_ON = 4'h6;
    localparam logic [3:0] OPT_WAIT_T0 = 4'h8;
    localparam logic [3:0] OPT_WAIT_T1 = 4'h9;
    localparam logic [3:0] OPT_WAIT_SWT = 4'hb;
    localparam logic [3:0] OPT_CHS_C0 = 4'hc;
    localparam logic [3:0] OPT_CHS_C1 = 4'hd;
    localparam logic [3:0] OPT_CHS_L0 = 4'he;
    localparam logic [3:0] OPT_BCAST = 4'hf;
    localparam logic [3:0] OPT_ADD_LAST = 4'h5;
    localparam logic [3:0] OPT_COPY_FIRST = 4'h8;
    localparam logic [3:0] OPT_COPY_LAST = 4'hd;

    // index of each limit target, add/copy order
    localparam logic [2:0] LIM_C0 = 3'h0;
    localparam logic [2:0] LIM_C1 = 3'h1;
    localparam logic [2:0] LIM_T0 = 3'h2;
    localparam logic [2:0] LIM_T1 = 3'h3;
    localparam logic [2:0] LIM_SD = 3'h4;
    localparam logic [2:0] LIM_L0 = 3'h5;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ADJ = 8'h08;
    localparam logic [7:0] ADDR_HOLD = 8'h0c;
    localparam logic [7:0] ADDR_LIM0 = 8'h10;
    localparam logic [7:0] ADDR_LIM_LAST = 8'h24;
    localparam logic [7:0] ADDR_BTE = 8'h28;
    localparam logic [7:0] ADDR_CHSEL = 8'h2c;
    localparam logic [7:0] ADDR_CNT0 = 8'h30;
    localparam logic [7:0] ADDR_CNT1 = 8'h34;
    localparam logic [7:0] ADDR_PROG = 8'h40;

    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_SDEN_BIT = 1;
    localparam int unsigned CTRL_SWT_BIT = 2;
    localparam int unsigned CTRL_RESTART_BIT = 3;

    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [7:0] RST_STEP = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // ****************************************
    // sequencer states and outputs
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_WAIT_T0 = 3'b010,
        ST_WAIT_T1 = 3'b011,
        ST_WAIT_SWT = 3'b100,
        ST_DELAY = 3'b101
    } tssd_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] chsel;
        logic [TRIG_W-1:0] trig;
    } tssd_out_t;

endpackage

// File: core/tssd_top.sv
// trigger sequencer step decoder: step program, limit registers, decoder
// assumes one 40 MHz clock, AXI4-Lite master, synchronous inputs
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module tssd_top
    import tssd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter and trigger consumers
    output tssd_out_t conv_out,
    output logic seq_busy
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a[1:0] == 2'b00) begin
            if (a <= ADDR_CNT1) begin
                hit = 1'b1;
            end else if (a >= ADDR_PROG) begin
                hit = (a[7] == 1'b0);
            end
        end
        return hit;
    endfunction

    function automatic logic [DATA_W-1:0] merge16(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] d,
        input logic [1:0] be
    );
        logic [DATA_W-1:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = d[7:0];
        end
        if (be[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // ****************************************
    // bus slave handshake
    // ****************************************
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [ADDR_W-1:0] waddr, next_waddr;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [1:0] wstrb, next_wstrb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic wr_go;
    logic [31:0] rd_mux;

    // register file and sequencer state
    tssd_state_t state, next_state;
    logic [PTR_W-1:0] ptr, next_ptr;
    logic run, next_run;
    logic sd_en, next_sd_en;
    logic swt, next_swt;
    logic swt_prev, next_swt_prev;
    logic [DATA_W-1:0] tmr, next_tmr;
    logic [DATA_W-1:0] lim [LIM_COUNT];
    logic [DATA_W-1:0] next_lim [LIM_COUNT];
    logic [DATA_W-1:0] adj, next_adj;
    logic [DATA_W-1:0] hold, next_hold;
    logic [DATA_W-1:0] bte, next_bte;
    logic [DATA_W-1:0] cnt0, next_cnt0;
    logic [DATA_W-1:0] cnt1, next_cnt1;
    logic [DATA_W-1:0] chsel, next_chsel;
    logic [TRIG_W-1:0] trig, next_trig;
    tssd_step_t prog [PROG_DEPTH];
    tssd_step_t next_prog [PROG_DEPTH];

    // write lands once address and data are both held
    assign wr_go = aw_held && w_held && !bvalid;

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (s_axi_araddr >= ADDR_PROG) begin
            rd_mux[7:0] = prog[s_axi_araddr[5:2]];
        end else if (s_axi_araddr >= ADDR_LIM0
                && s_axi_araddr <= ADDR_LIM_LAST) begin
            rd_mux[15:0] = lim[3'((s_axi_araddr - ADDR_LIM0) >> 2)];
        end else begin
            case (s_axi_araddr)
                ADDR_CTRL: begin
                    rd_mux[CTRL_RUN_BIT] = run;
                    rd_mux[CTRL_SDEN_BIT] = sd_en;
                    rd_mux[CTRL_SWT_BIT] = swt;
                end
                ADDR_STATUS: rd_mux[7:0] = {state, ptr, seq_busy};
                ADDR_ADJ: rd_mux[15:0] = adj;
                ADDR_HOLD: rd_mux[15:0] = hold;
                ADDR_BTE: rd_mux[15:0] = bte;
                ADDR_CHSEL: rd_mux[15:0] = chsel;
                ADDR_CNT0: rd_mux[15:0] = cnt0;
                ADDR_CNT1: rd_mux[15:0] = cnt1;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_waddr = waddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wdata = s_axi_wdata[15:0];
            next_wstrb = s_axi_wstrb[1:0];
        end
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_hit(waddr) ? RESP_OKAY : RESP_DECERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            // refused reads return zero, not a stale program word
            next_rdata = addr_hit(s_axi_araddr) ? rd_mux : 32'h0000_0000;
            next_rresp = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= '0;
            wdata <= RST_REG;
            wstrb <= 2'b00;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ****************************************
    // register file and step decoder
    // ****************************************
    assign seq_busy = (state != ST_IDLE);
    assign conv_out.chsel = chsel;
    assign conv_out.trig = trig;

    always_comb begin
        tssd_step_t step;
        logic done;
        logic [2:0] sel;
        step = prog[ptr];
        done = 1'b0;
        sel = 3'h0;
        next_state = state;
        next_ptr = ptr;
        next_run = run;
        next_sd_en = sd_en;
        next_swt = swt;
        next_swt_prev = swt;
        next_tmr = tmr;
        next_lim = lim;
        next_adj = adj;
        next_hold = hold;
        next_bte = bte;
        next_cnt0 = cnt0;
        next_cnt1 = cnt1;
        next_chsel = chsel;
        next_trig = '0;
        next_prog = prog;

        // software writes first; the step decoder overrides below
        if (wr_go && addr_hit(waddr)) begin
            if (waddr >= ADDR_PROG) begin
                if (wstrb[0]) begin
                    next_prog[waddr[5:2]] = wdata[7:0];
                end
            end else if (waddr >= ADDR_LIM0 && waddr <= ADDR_LIM_LAST) begin
                sel = 3'((waddr - ADDR_LIM0) >> 2);
                next_lim[sel] = merge16(lim[sel], wdata, wstrb);
            end else begin
                case (waddr)
                    ADDR_CTRL: begin
                        if (wstrb[0]) begin
                            next_run = wdata[CTRL_RUN_BIT];
                            next_sd_en = wdata[CTRL_SDEN_BIT];
                            next_swt = wdata[CTRL_SWT_BIT];
                            if (wdata[CTRL_RESTART_BIT]) begin
                                next_ptr = '0;
                            end
                        end
                    end
                    ADDR_ADJ: next_adj = merge16(adj, wdata, wstrb);
                    ADDR_HOLD: next_hold = merge16(hold, wdata, wstrb);
                    ADDR_BTE: next_bte = merge16(bte, wdata, wstrb);
                    ADDR_CNT0: next_cnt0 = merge16(cnt0, wdata, wstrb);
                    ADDR_CNT1: next_cnt1 = merge16(cnt1, wdata, wstrb);
                    default: next_adj = adj;
                endcase
            end
        end

        case (state)
            ST_IDLE: begin
                if (run) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                done = 1'b1;
                case (step.cmd)
                    CMD_CONTROL: begin
                        case (step.opt)
                            OPT_SD_OFF: next_sd_en = 1'b0;
                            OPT_SD_ON: next_sd_en = 1'b1;
                            OPT_WAIT_T0: begin
                                next_tmr = '0;
                                next_state = ST_WAIT_T0;
                                done = 1'b0;
                            end
                            OPT_WAIT_T1: begin
                                next_tmr = '0;
                                next_state = ST_WAIT_T1;
                                done = 1'b0;
                            end
                            OPT_WAIT_SWT: begin
                                next_state = ST_WAIT_SWT;
                                done = 1'b0;
                            end
                            OPT_CHS_C0: next_chsel = cnt0;
                            OPT_CHS_C1: next_chsel = cnt1;
                            OPT_CHS_L0: next_chsel = lim[LIM_L0];
                            OPT_BCAST: next_trig = bte;
                            default: next_trig = '0;
                        endcase
                    end
                    CMD_LIMIT: begin
                        // low nibble splits add from copy
                        if (step.opt <= OPT_ADD_LAST) begin
                            sel = step.opt[2:0];
                            next_lim[sel] = lim[sel] + adj;
                        end else if (step.opt >= OPT_COPY_FIRST
                                && step.opt <= OPT_COPY_LAST) begin
                            sel = 3'(step.opt - OPT_COPY_FIRST);
                            next_lim[sel] = hold;
                        end
                    end
                    default: next_trig = '0;
                endcase
            end
            ST_WAIT_T0: begin
                if (tmr == lim[LIM_T0]) begin
                    done = 1'b1;
                end else begin
                    next_tmr = tmr + 16'h0001;
                end
            end
            ST_WAIT_T1: begin
                if (tmr == lim[LIM_T1]) begin
                    done = 1'b1;
                end else begin
                    next_tmr = tmr + 16'h0001;
                end
            end
            ST_WAIT_SWT: begin
                // only a fresh rising edge counts, a held 1 does not
                if (swt && !swt_prev) begin
                    done = 1'b1;
                end
            end
            ST_DELAY: begin
                if (tmr == lim[LIM_SD]) begin
                    next_state = ST_EXEC;
                end else begin
                    next_tmr = tmr + 16'h0001;
                end
            end
            default: next_state = ST_IDLE;
        endcase

        // a finished step advances; delay inserted when enabled
        if (done) begin
            next_ptr = ptr + 4'h1;
            next_tmr = '0;
            next_state = next_sd_en ? ST_DELAY : ST_EXEC;
        end
        if (!run) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            ptr <= '0;
            run <= 1'b0;
            sd_en <= 1'b0;
            swt <= 1'b0;
            swt_prev <= 1'b0;
            tmr <= RST_REG;
            adj <= RST_REG;
            hold <= RST_REG;
            bte <= RST_REG;
            cnt0 <= RST_REG;
            cnt1 <= RST_REG;
            chsel <= RST_REG;
            trig <= '0;
            for (int i = 0; i < LIM_COUNT; i++) begin
                lim[i] <= RST_REG;
            end
            for (int i = 0; i < PROG_DEPTH; i++) begin
                prog[i] <= RST_STEP;
            end
        end else begin
            state <= next_state;
            ptr <= next_ptr;
            run <= next_run;
            sd_en <= next_sd_en;
            swt <= next_swt;
            swt_prev <= next_swt_prev;
            tmr <= next_tmr;
            adj <= next_adj;
            hold <= next_hold;
            bte <= next_bte;
            cnt0 <= next_cnt0;
            cnt1 <= next_cnt1;
            chsel <= next_chsel;
            trig <= next_trig;
            lim <= next_lim;
            prog <= next_prog;
        end
    end

endmodule

// File: tb/tb_trigger_sequencer_step_decode.sv
// bench of tssd_top: two step programs loaded and run over the bus
// assumes the consumer model logs broadcast pulses with cycle stamps
`timescale 1ns/1ps
module tb_trigger_sequencer_step_decode;
    import tssd_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, seq_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd_d;
    logic [1:0] rd_r;
    tssd_out_t conv_out;
    logic [15:0] seed = 16'h0057;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int lim[6];
    int adj, hold, bte, cnt0, cnt1;

    tssd_top u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .conv_out(conv_out),
        .seq_busy(seq_busy)
    );
    tssd_conv_model u_conv (.sys_clk(sys_clk), .conv_out(conv_out));

    always #12.5 sys_clk = ~sys_clk;

    // ********
    // helpers
    // ********
    task automatic end_sim();
        $display("counts: compared %0d mismatched %0d", n_compared,
            n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            $display("[FAIL] t=%0t hang exp=%h got=%h", $time, 1'b1, 1'b0);
            end_sim();
        end
    end

    function automatic int rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return int'(seed[7:0]);
    endfunction

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // bready stays high, so only the valids are ever lowered
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
    endtask

    task automatic rdchk(input logic [7:0] a, input int e);
        rd(a);
        chk({30'h0, RESP_OKAY}, {30'h0, rd_r});
        chk(32'(e), rd_d);
    endtask

    task automatic load(input logic [127:0] p);
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_PROG + 8'(4 * i), {8'h00, p[127 - 8 * i -: 8]});
        end
    endtask

    task automatic wait_swt();
        do begin
            rd(ADDR_STATUS);
        end while (rd_d[7:5] !== 3'h4);
    endtask

    task automatic gap(input int k);
        chk(32'(hold + 3), 32'(u_conv.t_q[k + 1] - u_conv.t_q[k]));
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(8'h38);
        chk({30'h0, RESP_DECERR}, {30'h0, rd_r});
        chk(32'h0, rd_d);
        $display("test 1 unmapped read done");
        adj = rnd();
        bte = rnd() | 1;
        cnt0 = rnd();
        wr(ADDR_ADJ, 16'(adj));
        wr(ADDR_BTE, 16'(bte));
        wr(ADDR_CNT0, 16'(cnt0));
        for (int i = 0; i < 6; i++) begin
            lim[i] = rnd();
            wr(ADDR_LIM0 + 8'(4 * i), 16'(lim[i]));
        end
        load(128'h10111213_14151617_1e072f0c_0a0f010b);
        wr(ADDR_CTRL, 16'h0001);
        wait_swt();
        for (int i = 0; i < 6; i++) begin
            rdchk(ADDR_LIM0 + 8'(4 * i), lim[i] + adj);
        end
        rdchk(ADDR_CHSEL, cnt0);
        chk(32'h1, 32'(u_conv.t_q.size()));
        wr(ADDR_CTRL, 16'h0008);
        $display("test 2 add and reserved steps done");
        hold = rnd();
        cnt1 = rnd();
        wr(ADDR_HOLD, 16'(hold));
        wr(ADDR_CNT1, 16'(cnt1));
        load(128'h18191a1b_1c1d0d0f_080f090f_060f020b);
        wr(ADDR_CTRL, 16'h0001);
        wait_swt();
        for (int i = 0; i < 6; i++) begin
            rdchk(ADDR_LIM0 + 8'(4 * i), hold);
        end
        rdchk(ADDR_CHSEL, cnt1);
        chk(32'h5, 32'(u_conv.t_q.size()));
        gap(1);
        gap(2);
        gap(3);
        $display("test 3 copy and wait steps done");
        // swap step 6 to the L0 limit select before waking
        wr(ADDR_PROG + 8'h18, 16'h000e);
        wr(ADDR_CTRL, 16'h0005);
        while (u_conv.t_q.size() < 9) @(posedge sys_clk);
        wait_swt();
        repeat (40) @(posedge sys_clk);
        chk(32'h9, 32'(u_conv.t_q.size()));
        rdchk(ADDR_CHSEL, hold);
        gap(5);
        gap(6);
        gap(7);
        foreach (u_conv.v_q[k]) chk(32'(bte), 32'(u_conv.v_q[k]));
        chk(32'h1, 32'(seq_busy));
        wr(ADDR_CTRL, 16'h0000);
        repeat (2) @(posedge sys_clk);
        chk(32'h0, 32'(seq_busy));
        $display("test 4 software trigger done");
        end_sim();
    end
endmodule

// File: tb/tssd_assertions.sv
// checker of bus handshakes and sequencer outputs of tssd_top
// assumes it is bound to tssd_top and sees only its ports
`timescale 1ns/1ps
module tssd_checker
    import tssd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sequencer side
    input wire tssd_out_t conv_out,
    input wire logic seq_busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // ********
    // sequencer outputs
    // ********
    AST_TRIG_WHILE_BUSY: assert property (
        conv_out.trig != 16'h0000 |-> $past(seq_busy))
        else $error("trigger pulse without a running step");
    AST_CHSEL_FROM_STEP: assert property (
        $changed(conv_out.chsel) |-> $past(seq_busy))
        else $error("channel select moved while idle");
    AST_BUSY_START: assert property (
        $rose(seq_busy) |-> $past(s_axi_bvalid))
        else $error("sequencer started without a write");

    // ********
    // register bus
    // ********
    AST_WRITE_ANSWER: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write response late");
    AST_WRITE_BLOCK: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_BVALID_DROP: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_READ_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid [*1] ##1 1'b1)
        else $error("read data late");
    AST_READ_BLOCK: assert property (
        s_axi_rvalid && s_axi_rready |-> !s_axi_arready ##1 !s_axi_rvalid)
        else $error("read handshake broken");

    COV_TRIG: cover property (conv_out.trig != 16'h0000);
    COV_CHSEL: cover property ($changed(conv_out.chsel));
    COV_STOP: cover property ($fell(seq_busy));
endmodule

bind tssd_top tssd_checker u_chk (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .conv_out(conv_out),
    .seq_busy(seq_busy)
);

// File: tb/tssd_conv_model.sv
// converter and trigger consumer: logs every broadcast pulse
// assumes trigger outputs are synchronous one-cycle pulses
`timescale 1ns/1ps
module tssd_conv_model
    import tssd_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // from the sequencer
    input wire tssd_out_t conv_out
);
    int cyc = 0;
    int t_q[$];
    logic [TRIG_W-1:0] v_q[$];

    // cycle stamps let the bench measure step spacing
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (conv_out.trig != 16'h0000) begin
            t_q.push_back(cyc);
            v_q.push_back(conv_out.trig);
        end
    end
endmodule
